// File: isc_idle_coord.sv
// Function
// [R1] legacy idle read becomes monitor-wait request internally
// [R2] level two maps C3, three maps C6
// [R3] reads outside trap range complete normally
// [R4] redirected requests carry sub-state zero
// [R5] redirected requests break on masked interrupt
// [R6] core state is lowest thread state
// [R7] interrupt or monitor hit returns core C0
// [R8] thread interrupt wakes one thread, core C0
// [R9] system reset reinitialises every core
// [R10] C1 only when all threads halted; snoops served (code enters C1 once every thread has a request, halt bit not checked)
// [R11] C3 flushes caches, stops clocks, ignores snoops
// [R12] C6 saves state before power off, restores
// [R13] auto-demotion limits C6/C3 until residency established
// [R14] auto-demotion off at reset, set by config
// [R15] package request lowest core; low-freq halt option
// [R16] package moves between idle states directly
// [R17] core break wakes core and package C0
// [R18] memory break serviced then previous or shallower
// [R19] package C0 while core C0/C1 or no grant
// [R20] low-freq halt: frequency first, voltage after
// [R21] low-freq halt on hint, limit or promotion
// [R22] package C3 when cores C3+ and granted
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "isc_map.svh"
module isc_idle_coord
  import isc_pkg::*;
#(
  parameter int NCORE = 2,
  parameter int NTHR  = 2
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  // apb slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [11:0]           paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // thread requests (same clock)
  input  wire isc_req_t [NCORE*NTHR-1:0] thr_req_in,
  input  wire logic [NCORE*NTHR-1:0] legacy_idle_level_read_in,
  input  wire logic [NCORE*NTHR-1:0] idle_level_three_read_in,
  input  wire logic [15:0]           io_addr_in,
  input  wire logic [NCORE*NTHR-1:0] thr_irq_in,
  input  wire logic [NCORE*NTHR-1:0] irq_masked_in,
  input  wire logic [NCORE*NTHR-1:0] mon_hit_in,
  input  wire logic                  mem_break_in,
  input  wire logic                  plat_grant_in,
  input  wire logic                  plat_shallow_in,
  output logic      [NCORE*NTHR-1:0] io_fallthru_out,
  output logic      [NCORE*NTHR-1:0] thr_wake_out,
  output logic      [NCORE*NTHR-1:0] brk_fwd_out,
  output isc_cst_t  [NCORE-1:0]      core_cst_out,
  output isc_act_t  [NCORE-1:0]      core_act_out,
  output isc_cst_t                   pkg_req_out,
  output isc_cst_t                   pkg_cst_out,
  output logic                       lfh_out,
  output logic                       freq_low_out,
  output logic                       volt_low_out,
  output logic                       mem_service_out
);
  localparam int NT = NCORE * NTHR;
  localparam int STEP = `ISC_SEQ_STEP_CYC;

  // lower of two states
  function automatic isc_cst_t cmin(input isc_cst_t a, input isc_cst_t b);
    cmin = (a < b) ? a : b;
  endfunction : cmin

  // registers
  logic [31:0]    cfg;          // configuration control
  logic [15:0]    trap_lo;      // io trap low bound
  logic [15:0]    trap_hi;      // io trap high bound
  logic [7:0]     demote_thr;   // residency needed
  isc_req_t [NT-1:0] thr;       // live thread requests
  logic [7:0]     resid [NCORE];// residency history
  isc_cst_t [NCORE-1:0] core_req; // resolved, before sequencing
  logic [3:0]     seq_cnt;      // package voltage step timer
  isc_cst_t       pkg_min;      // shallowest core state
  logic           all_hint;     // every thread hints low-freq halt
  logic           all_halt;     // every thread has halted

  // apb access
  wire apb_acc = psel_in && penable_in;
  wire apb_wr  = apb_acc && pwrite_in;

  // register writes
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cfg        <= `ISC_CFG_RST; // R14
      trap_lo    <= `ISC_TRAP_LO_RST;
      trap_hi    <= `ISC_TRAP_HI_RST;
      demote_thr <= `ISC_DEMOTE_THR_RST;
    end else if (apb_wr) begin
      case (paddr_in)
        `ISC_OFF_CFG:        cfg        <= pwdata_in; // R14
        `ISC_OFF_TRAP_LO:    trap_lo    <= pwdata_in[15:0];
        `ISC_OFF_TRAP_HI:    trap_hi    <= pwdata_in[15:0];
        `ISC_OFF_DEMOTE_THR: demote_thr <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // apb answer: one-wait-free, registered
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      if (psel_in && !penable_in) begin
        case (paddr_in)
          `ISC_OFF_CFG:        prdata_out <= cfg;
          `ISC_OFF_TRAP_LO:    prdata_out <= {16'h0000, trap_lo};
          `ISC_OFF_TRAP_HI:    prdata_out <= {16'h0000, trap_hi};
          `ISC_OFF_STATUS:     prdata_out <= {24'h000000, lfh_out,
            freq_low_out, volt_low_out, mem_service_out,
            2'(pkg_req_out), 2'(pkg_cst_out)};
          `ISC_OFF_DEMOTE_THR: prdata_out <= {24'h000000, demote_thr};
          default:             pslverr_out <= 1'b1; // unmapped
        endcase
      end
    end
  end

  // legacy read decode and thread request capture
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      thr             <= '0; // R9
      io_fallthru_out <= '0;
      thr_wake_out    <= '0;
      brk_fwd_out     <= '0;
    end else begin
      io_fallthru_out <= '0;
      thr_wake_out    <= '0;
      brk_fwd_out     <= '0;
      for (int t = 0; t < NT; t++) begin
        // wake only this thread on its own event
        if (thr[t].valid && ((thr_irq_in[t] &&
            (!irq_masked_in[t] || thr[t].brk_if)) || mon_hit_in[t])) begin
          thr[t]          <= '0; // R7 R8
          thr_wake_out[t] <= 1'b1; // R8
          brk_fwd_out[t]  <= thr_irq_in[t]; // R17
        end else if (legacy_idle_level_read_in[t]) begin
          if (cfg[`ISC_CFG_REDIR_EN] && io_addr_in >= trap_lo &&
              io_addr_in <= trap_hi) begin
            // internal only, no system read issued R1
            thr[t].valid    <= 1'b1;
            thr[t].state    <= idle_level_three_read_in[t] ?
                               ISC_C6 : ISC_C3; // R2
            thr[t].lfh_hint <= 1'b0; // R4
            thr[t].halt     <= 1'b0;
            thr[t].brk_if   <= cfg[`ISC_CFG_BRK_IF]; // R5
          end else begin
            io_fallthru_out[t] <= 1'b1; // R3
          end
        end else if (thr_req_in[t].valid) begin
          thr[t] <= thr_req_in[t];
        end
      end
    end
  end

  // core resolution with auto-demotion
  always_comb begin
    for (int c = 0; c < NCORE; c++) begin
      isc_cst_t m;
      logic all_idle;
      m = ISC_C6;
      all_idle = 1'b1;
      for (int k = 0; k < NTHR; k++) begin
        if (!thr[c*NTHR+k].valid) all_idle = 1'b0;
        m = cmin(m, thr[c*NTHR+k].valid ? thr[c*NTHR+k].state : ISC_C0); // R6
      end
      if (!all_idle) m = ISC_C0; // R10
      if (resid[c] < demote_thr) begin
        if (cfg[`ISC_CFG_DEMOTE_C1] && m != ISC_C0) m = ISC_C1; // R13
        else if (cfg[`ISC_CFG_DEMOTE_C3] && m == ISC_C6) m = ISC_C3; // R13
      end
      core_req[c] = m;
    end
  end

  // residency history and core action sequencing
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      core_cst_out <= '0; // R9
      core_act_out <= '0;
      for (int c = 0; c < NCORE; c++) resid[c] <= 8'h00;
    end else begin
      for (int c = 0; c < NCORE; c++) begin
        if (core_cst_out[c] != ISC_C0 && resid[c] != 8'hFF)
          resid[c] <= resid[c] + 8'h01;
        else if (core_req[c] == ISC_C0 && core_cst_out[c] == ISC_C0 &&
                 resid[c] != 8'h00 && resid[c] < demote_thr)
          resid[c] <= 8'h00; // short residency resets history
        core_act_out[c].restore <= 1'b0;
        case (core_req[c])
          ISC_C0: begin
            core_cst_out[c] <= ISC_C0; // R7
            core_act_out[c] <= '0;
            // restore after repower R12
            core_act_out[c].restore <= core_act_out[c].pwr_off;
          end
          ISC_C1: begin
            core_cst_out[c] <= ISC_C1; // R10 snoops still served
            core_act_out[c] <= '0;
          end
          ISC_C3: begin
            core_act_out[c].flush <= 1'b1; // R11
            core_act_out[c].save  <= 1'b0;
            core_act_out[c].pwr_off <= 1'b0;
            // clocks stop once flush is in flight
            core_act_out[c].clk_stop <= core_act_out[c].flush; // R11
            if (core_act_out[c].flush) core_cst_out[c] <= ISC_C3;
          end
          default: begin
            core_act_out[c].flush <= 1'b1;
            core_act_out[c].clk_stop <= core_act_out[c].flush;
            core_act_out[c].save  <= 1'b1; // R12
            // voltage cut only after save done
            core_act_out[c].pwr_off <= core_act_out[c].save; // R12
            if (core_act_out[c].save) core_cst_out[c] <= ISC_C6;
          end
        endcase
      end
    end
  end

  // shallowest core state and all-thread hint or halt
  always_comb begin
    pkg_min  = ISC_C6;
    all_hint = 1'b1;
    all_halt = 1'b1;
    for (int c = 0; c < NCORE; c++)
      pkg_min = cmin(pkg_min, core_cst_out[c]); // R15
    for (int t = 0; t < NT; t++) begin
      if (!(thr[t].valid && thr[t].lfh_hint)) all_hint = 1'b0;
      if (!(thr[t].valid && thr[t].halt)) all_halt = 1'b0;
    end
  end

  // package request and resolved package state
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pkg_req_out     <= ISC_C0;
      pkg_cst_out     <= ISC_C0;
      lfh_out         <= 1'b0;
      mem_service_out <= 1'b0;
    end else begin
      pkg_req_out <= pkg_min;
      mem_service_out <= 1'b0;
      lfh_out <= (pkg_min != ISC_C0) && cfg[`ISC_CFG_LFH_EN] && (all_hint ||
        (pkg_min != ISC_C1 && cfg[`ISC_CFG_LIMIT_C1]) ||
        (all_halt && cfg[`ISC_CFG_PROMOTE])); // R15 R21
      if (|brk_fwd_out) begin
        pkg_cst_out <= ISC_C0; // R17
      end else if (mem_break_in && pkg_cst_out != ISC_C0) begin
        mem_service_out <= 1'b1; // R18
        if (plat_shallow_in) pkg_cst_out <= ISC_C1; // R18
      end else if (pkg_min <= ISC_C1 || !plat_grant_in) begin
        // deeper cores may sit under a C0 package R16
        pkg_cst_out <= ISC_C0; // R19
      end else if (plat_shallow_in && pkg_cst_out == ISC_C1) begin
        pkg_cst_out <= ISC_C1; // R18 platform keeps it shallower
      end else if (cfg[`ISC_CFG_LIMIT_C1]) begin
        pkg_cst_out <= ISC_C1; // R21
      end else begin
        pkg_cst_out <= ISC_C3; // R16 R22 package C6 stays out
      end
    end
  end

  // low-frequency halt: frequency then voltage
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      freq_low_out <= 1'b0;
      volt_low_out <= 1'b0;
      seq_cnt      <= 4'h0;
    end else if (!lfh_out) begin
      freq_low_out <= 1'b0;
      volt_low_out <= 1'b0;
      seq_cnt      <= 4'h0;
    end else begin
      freq_low_out <= 1'b1; // R20
      if (freq_low_out && seq_cnt == 4'(STEP))
        volt_low_out <= 1'b1; // R20
      else if (freq_low_out)
        seq_cnt <= seq_cnt + 4'h1;
    end
  end

  // checks
  property p_volt_after_freq;
    @(posedge core_clk_in) disable iff (rst_in)
      $rose(volt_low_out) |-> $past(freq_low_out, 2);
  endproperty
  a_volt_after_freq: assert property (p_volt_after_freq) // R20
    else $error("voltage lowered before frequency");

  property p_pwr_after_save;
    @(posedge core_clk_in) disable iff (rst_in)
      $rose(core_act_out[0].pwr_off) |-> $past(core_act_out[0].save);
  endproperty
  a_pwr_after_save: assert property (p_pwr_after_save) // R12
    else $error("core powered off without saved state");

  property p_pkg_c0_nogrant;
    @(posedge core_clk_in) disable iff (rst_in)
      !plat_grant_in && !mem_break_in |=> pkg_cst_out == ISC_C0;
  endproperty
  a_pkg_c0_nogrant: assert property (p_pkg_c0_nogrant) // R19
    else $error("package deep without grant");

  property p_brk_c0;
    @(posedge core_clk_in) disable iff (rst_in)
      |brk_fwd_out |=> pkg_cst_out == ISC_C0;
  endproperty
  a_brk_c0: assert property (p_brk_c0) // R17
    else $error("package not in C0 after core break");

  property p_c3_flush;
    @(posedge core_clk_in) disable iff (rst_in)
      core_cst_out[0] == ISC_C3 |-> core_act_out[0].flush;
  endproperty
  a_c3_flush: assert property (p_c3_flush) // R11
    else $error("core in C3 without flush");

  property p_demote_off;
    @(posedge core_clk_in) disable iff (rst_in)
      $fell(rst_in) |-> !cfg[`ISC_CFG_DEMOTE_C3] && !cfg[`ISC_CFG_DEMOTE_C1];
  endproperty
  a_demote_off: assert property (p_demote_off) // R14
    else $error("auto-demotion active after reset");

  property p_redirect_quiet;
    @(posedge core_clk_in) disable iff (rst_in)
      legacy_idle_level_read_in[0] && !thr[0].valid && cfg[`ISC_CFG_REDIR_EN]
      && io_addr_in >= trap_lo && io_addr_in <= trap_hi
      |=> !io_fallthru_out[0] && thr[0].valid && !thr[0].lfh_hint;
  endproperty
  a_redirect_quiet: assert property (p_redirect_quiet) // R1
    else $error("redirected read leaked or kept sub-state");

  property p_out_of_range;
    @(posedge core_clk_in) disable iff (rst_in)
      legacy_idle_level_read_in[0] && !thr[0].valid &&
      (io_addr_in < trap_lo || io_addr_in > trap_hi) |=> io_fallthru_out[0];
  endproperty
  a_out_of_range: assert property (p_out_of_range) // R3
    else $error("out of range read not passed through");
endmodule : isc_idle_coord
`default_nettype wire

// File: isc_map.svh
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH
// register byte offsets
`define ISC_OFF_CFG        12'h000
`define ISC_OFF_TRAP_LO    12'h004
`define ISC_OFF_TRAP_HI    12'h008
`define ISC_OFF_STATUS     12'h00C
`define ISC_OFF_DEMOTE_THR 12'h010
// config field positions
`define ISC_CFG_DEMOTE_C3  0
`define ISC_CFG_DEMOTE_C1  1
`define ISC_CFG_LIMIT_C1   2
`define ISC_CFG_LFH_EN     3
`define ISC_CFG_PROMOTE    4
`define ISC_CFG_REDIR_EN   5
`define ISC_CFG_BRK_IF     6
// reset values
`define ISC_CFG_RST        32'h0000_0040
`define ISC_TRAP_LO_RST    16'h0000
`define ISC_TRAP_HI_RST    16'h0000
`define ISC_DEMOTE_THR_RST 8'h10
// sequencing timing
`define ISC_SEQ_STEP_NS    16
`define ISC_CLK_NS         8
`define ISC_SEQ_STEP_CYC   ((`ISC_SEQ_STEP_NS + `ISC_CLK_NS - 1) / `ISC_CLK_NS)
`endif

// File: isc_pkg.sv
`default_nettype none
package isc_pkg;
  // idle state codes, numerically ordered
  typedef enum logic [1:0] {
    ISC_C0 = 2'b00,
    ISC_C1 = 2'b01,
    ISC_C3 = 2'b10,
    ISC_C6 = 2'b11
  } isc_cst_t;
  // one thread request
  typedef struct packed {
    logic     valid;
    isc_cst_t state;
    logic     lfh_hint;
    logic     halt;
    logic     brk_if;
  } isc_req_t;
  // per-core power actions
  typedef struct packed {
    logic flush;
    logic clk_stop;
    logic save;
    logic pwr_off;
    logic restore;
  } isc_act_t;
endpackage : isc_pkg
`default_nettype wire

// File: isc_plat_model.sv
`timescale 1ns/1ps
`default_nettype none
// platform side: grants deep package states after a set lag
module isc_plat_model
  import isc_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire isc_cst_t   pkg_req_in,
  input  wire logic       allow_in,
  input  wire logic       shallow_cmd_in,
  input  wire logic [3:0] lag_in,
  output logic            grant_out,
  output logic            shallow_out
);
  logic [3:0] lag_cnt; // cycles the deep request has been seen
  // grant only after the request has stood for the lag, drop at once
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !allow_in || pkg_req_in < ISC_C3) begin
      lag_cnt   <= 4'h0;
      grant_out <= 1'b0;
    end else if (lag_cnt >= lag_in) begin
      grant_out <= 1'b1;
    end else begin
      lag_cnt <= lag_cnt + 4'h1;
    end
  end
  // shallower-state wish, held as a level
  always_ff @(posedge core_clk_in) begin
    shallow_out <= rst_in ? 1'b0 : shallow_cmd_in;
  end
endmodule : isc_plat_model
`default_nettype wire

// File: isc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import isc_pkg::*;
  logic             core_clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic             pready, pslverr, er;
  isc_req_t [3:0]   thr = '0;
  logic [3:0]       leg = 4'h0, l3 = 4'h0, irq = 4'h0, msk = 4'h0;
  logic [3:0]       mon = 4'h0, ft, wake, brk;
  logic [15:0]      ioa = 16'h0000;
  logic             mbrk = 1'b0, grant, shal, allow = 1'b0, shcmd = 1'b0;
  logic [3:0]       lag = 4'h3;
  isc_cst_t [1:0]   ccst;
  isc_act_t [1:0]   act;
  isc_cst_t         preq, pcst;
  logic             lfh, fl, vl, msrv, ft_seen;
  int               num_errors = 0, checks_done = 0, seed = 92003, i;
  isc_cst_t         a, b;
  always #4 core_clk_in = ~core_clk_in;
  isc_idle_coord #(.NCORE(2), .NTHR(2)) isc_idle_coord_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .thr_req_in(thr),
    .legacy_idle_level_read_in(leg), .idle_level_three_read_in(l3),
    .io_addr_in(ioa), .thr_irq_in(irq), .irq_masked_in(msk),
    .mon_hit_in(mon), .mem_break_in(mbrk), .plat_grant_in(grant),
    .plat_shallow_in(shal), .io_fallthru_out(ft), .thr_wake_out(wake),
    .brk_fwd_out(brk), .core_cst_out(ccst), .core_act_out(act),
    .pkg_req_out(preq), .pkg_cst_out(pcst), .lfh_out(lfh),
    .freq_low_out(fl), .volt_low_out(vl), .mem_service_out(msrv));
  isc_plat_model isc_plat_model_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .pkg_req_in(preq),
    .allow_in(allow), .shallow_cmd_in(shcmd), .lag_in(lag),
    .grant_out(grant), .shallow_out(shal));
  // sticky record of any fall-through pulse
  always @(posedge core_clk_in) if (ft !== 4'h0) ft_seen = 1'b1;
  // watched outputs by index, for the bounded waits
  function automatic logic [31:0] obs(int k);
    case (k)
      0: obs = 32'(ccst[0]);
      1: obs = 32'(ccst[1]);
      2: obs = 32'(pcst);
      3: obs = 32'(preq);
      4: obs = 32'(act[0]);
      5: obs = {30'h0, fl, vl};
      6: obs = {31'h0, lfh};
      7: obs = {28'h0, wake};
      8: obs = {28'h0, ft};
      10: obs = {28'h0, brk};
      default: obs = {31'h0, msrv};
    endcase
  endfunction : obs
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  // expected core state: the shallower of two thread requests
  function automatic isc_cst_t exp_min(isc_cst_t x, isc_cst_t y);
    exp_min = (x < y) ? x : y;
  endfunction : exp_min
  // bounded wait for a watched output to reach a value
  task automatic wt(int k, logic [31:0] e, string n);
    for (int j = 0; j < 60 && obs(k) !== e; j++) @(posedge core_clk_in);
    chk(n, e, obs(k));
    if (obs(k) !== e) results(); // limit ran out
  endtask : wt
  // one apb transfer, waits for pready with a bound
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1; pwr <= w; paddr <= ad; pwdata <= d;
    @(posedge core_clk_in);
    pen <= 1'b1;
    for (int j = 0; j < 20; j++) begin
      @(posedge core_clk_in);
      if (pready === 1'b1) break;
    end
    chk("pready", 1, pready);
    if (pready !== 1'b1) results(); // limit ran out
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  // one-cycle request pulse on the threads in m
  task automatic rq(logic [3:0] m, isc_cst_t s, logic h, logic hint);
    @(posedge core_clk_in);
    for (int t = 0; t < 4; t++)
      if (m[t]) thr[t] <= '{1'b1, s, hint, h, 1'b0};
    @(posedge core_clk_in);
    for (int t = 0; t < 4; t++) thr[t].valid <= 1'b0;
  endtask : rq
  // one-cycle legacy idle read pulse
  task automatic lg(logic [3:0] m, logic three, logic [15:0] ad);
    @(posedge core_clk_in);
    leg <= m; l3 <= three ? m : 4'h0; ioa <= ad;
    @(posedge core_clk_in);
    leg <= 4'h0;
  endtask : lg
  // monitor hit on every thread brings all cores back
  task automatic wake_all();
    @(posedge core_clk_in);
    mon <= 4'hF;
    @(posedge core_clk_in);
    mon <= 4'h0;
    wt(0, 0, "core0 woken");
    wt(1, 0, "core1 woken");
  endtask : wake_all
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    wt(0, 0, "core0 reset");
    apb(1'b0, 12'h000, 32'h0); chk("cfg reset", 32'h40, rd);
    apb(1'b0, 12'h010, 32'h0); chk("thr reset", 32'h10, rd);
    apb(1'b0, 12'h100, 32'h0); chk("unmapped err", 1, er);
    apb(1'b1, 12'h000, 32'h41);
    rq(4'h3, ISC_C6, 1'b0, 1'b0); wt(0, 2, "demoted c3");
    wake_all();
    apb(1'b1, 12'h000, 32'h40);
    lg(4'h1, 1'b0, 16'h0410); wt(8, 1, "redir off");
    apb(1'b1, 12'h000, 32'h60);
    apb(1'b1, 12'h004, 32'h400);
    apb(1'b1, 12'h008, 32'h4FF);
    lg(4'h4, 1'b1, 16'h0500); wt(8, 4, "out of range");
    @(negedge core_clk_in); ft_seen = 1'b0;
    lg(4'h3, 1'b1, 16'h0410); wt(4, 5'h14, "save first");
    wt(0, 3, "level three c6");
    chk("no io read", 0, ft_seen);
    @(posedge core_clk_in); irq <= 4'h1; msk <= 4'h1;
    wt(7, 1, "masked irq wake");
    chk("break forwarded", 1, obs(10));
    wt(0, 0, "one thread core c0");
    @(posedge core_clk_in); irq <= 4'h0; msk <= 4'h0;
    wake_all();
    lg(4'h3, 1'b0, 16'h0480); wt(4, 5'h10, "flush first");
    wt(0, 2, "level two c3");
    rq(4'hC, ISC_C3, 1'b0, 1'b0); wt(3, 2, "pkg req c3");
    chk("no grant c0", 0, obs(2));
    allow <= 1'b1; wt(2, 2, "pkg c3 granted");
    @(posedge core_clk_in); mbrk <= 1'b1;
    @(posedge core_clk_in); mbrk <= 1'b0;
    wt(9, 1, "mem serviced deep"); chk("deep kept", 2, obs(2));
    lag <= 4'h0; shcmd <= 1'b1;
    @(posedge core_clk_in); mbrk <= 1'b1;
    @(posedge core_clk_in); mbrk <= 1'b0;
    wt(9, 1, "mem serviced"); wt(2, 1, "shallower kept");
    repeat (4) @(posedge core_clk_in);
    chk("shallower held", 1, obs(2));
    shcmd <= 1'b0; allow <= 1'b0;
    wake_all(); wt(2, 0, "pkg c0 on wake");
    rq(4'h4, ISC_C1, 1'b1, 1'b0); repeat (8) @(posedge core_clk_in);
    chk("one thread halt", 0, obs(1));
    rq(4'h8, ISC_C3, 1'b0, 1'b0); wt(1, 1, "core min c1");
    wake_all();
    apb(1'b1, 12'h000, 32'h68);
    rq(4'hF, ISC_C1, 1'b1, 1'b1); wt(6, 1, "lfh by hint");
    wt(5, 2, "freq before volt");
    wt(5, 3, "volt after freq");
    wake_all(); apb(1'b1, 12'h000, 32'h60);
    for (i = 0; i < 20; i++) begin
      a = isc_cst_t'(1 + {$random(seed)} % 3);
      b = isc_cst_t'(1 + {$random(seed)} % 3);
      @(posedge core_clk_in);
      thr[2] <= '{1'b1, a, 1'b0, a == ISC_C1, 1'b0};
      thr[3] <= '{1'b1, b, 1'b0, b == ISC_C1, 1'b0};
      @(posedge core_clk_in);
      thr[2].valid <= 1'b0; thr[3].valid <= 1'b0;
      wt(1, 32'(exp_min(a, b)), "random core min");
      chk("pkg req min", 0, obs(3));
      wake_all();
    end
    // mid-run reset with core one deep
    rq(4'hC, ISC_C6, 1'b0, 1'b0); wt(1, 3, "pre reset c6");
    @(posedge core_clk_in); rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0; chk("reset core1", 0, obs(1));
    repeat (2) @(posedge core_clk_in);
    chk("core1 stays c0", 0, obs(1));
    apb(1'b0, 12'h000, 32'h0); chk("cfg mid reset", 32'h40, rd);
    // demotion straight to C1
    apb(1'b1, 12'h000, 32'h42);
    rq(4'hC, ISC_C6, 1'b0, 1'b0); wt(1, 1, "demoted c1");
    wake_all();
    // low-freq halt by auto-promotion of halted threads
    apb(1'b1, 12'h000, 32'h58);
    rq(4'hF, ISC_C1, 1'b1, 1'b0); wt(6, 1, "lfh by promotion");
    wake_all();
    // package limited to C1 with deep cores and a grant
    apb(1'b1, 12'h000, 32'h4C); allow <= 1'b1;
    rq(4'hF, ISC_C3, 1'b0, 1'b0); wt(2, 1, "limit c1");
    chk("lfh by limit", 1, obs(6));
    results();
  end
endmodule : testbench
`default_nettype wire
